// >>> pkg/etpirq_pkg.sv
package etpirq_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_RESET_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_CTRL_MAIN     = 4'h1;
    localparam logic [3:0] ADDR_CTRL_SECOND   = 4'h2;
    localparam logic [3:0] ADDR_CTRL_THIRD    = 4'h3;
    localparam logic [3:0] ADDR_TIMER_LOW     = 4'h4;
    localparam logic [3:0] ADDR_TIMER_HIGH    = 4'h5;
    localparam logic [3:0] ADDR_TIMER_CFG     = 4'h6;
    localparam logic [3:0] ADDR_EVT_STATUS    = 4'h7;
    localparam logic [3:0] ADDR_EVT_ENABLE    = 4'h8;
    localparam logic [3:0] ADDR_EVT_CLEAR     = 4'h9;
    localparam logic [3:0] ADDR_PORTB_SNAP    = 4'hA;
    // Reset-status register fields
    localparam int RST_PRIO_BIT      = 7;
    localparam logic [7:0] RST_STATUS_RESET = 8'h1C;
    localparam logic [7:0] RST_WR_MASK      = 8'h93;
    // Main control fields
    localparam int MAIN_GIE = 7;
    localparam int MAIN_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int MAIN_TIMER_ZERO_IRQ_ENABLE = 5;
    localparam int MAIN_X0IE = 4;
    localparam int MAIN_PCIE = 3;
    localparam int MAIN_T0IF = 2;
    localparam int MAIN_X0IF = 1;
    localparam int MAIN_PCIF = 0;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    // Second control fields
    localparam int SEC_EDGE0 = 6;
    localparam int SEC_EDGE1 = 5;
    localparam int SEC_EDGE2 = 4;
    localparam int SEC_T0IP  = 2;
    localparam int SEC_PCIP  = 0;
    localparam logic [7:0] SEC_RESET   = 8'hF5;
    localparam logic [7:0] SEC_WR_MASK = 8'hF5;
    // Third control fields
    localparam int THR_X2IP = 7;
    localparam int THR_X1IP = 6;
    localparam int THR_X2IE = 4;
    localparam int THR_X1IE = 3;
    localparam int THR_X2IF = 1;
    localparam int THR_X1IF = 0;
    localparam logic [7:0] THR_RESET   = 8'hC0;
    localparam logic [7:0] THR_WR_MASK = 8'hDB;
    // Event status layout: one bit per source
    localparam int EVT_X0 = 0;
    localparam int EVT_X1 = 1;
    localparam int EVT_X2 = 2;
    localparam int EVT_T0 = 3;
    localparam int EVT_PC = 4;
    localparam int EVT_W  = 5;
    localparam logic [15:0] TIMER_MAX16 = 16'hFFFF;
    localparam logic [7:0]  TIMER_MAX8  = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage : etpirq_pkg

// >>> design/etpirq_top.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// R1: Priority master bit 7 set gives two levels; clear gives single-level mode.
// R2: External inputs detect rising edge when edge-select is 1, falling when 0.
// R3: Valid edge sets input flag; enable clear blocks the interrupt.
// R4: Software clears external flag before re-enabling; hardware never clears it.
// R5: External interrupt wakes from sleep if its enable was set beforehand.
// R6: After wake, vector only when global enable set, else continue.
// R7: External 1 and 2 priorities are third control bits 6 and 7.
// R8: External 0 has no priority bit and is always high priority.
// R9: Eight-bit timer wrap FFh to 00h sets timer overflow flag.
// R10: Sixteen-bit timer wrap to 0000h sets the same overflow flag.
// R11: Timer interrupt enabled by main bit 5, priority second bit 2.
// R12: Change on port B pins 7 to 4 sets main control bit 0.
// R13: Pin-change interrupt enabled by main bit 3, priority second bit 0.
// R14: Taking an interrupt pushes the return program counter.
// R15: Taking an interrupt copies working, status and bank registers to shadows.
// R16: Reset-status bits 6 and 5 always read zero.
// R17: Without priorities, peripheral enable must be set for peripheral sources.
// R18: Individual priority bits act only while priority master bit set.
// R19: Request only when flag, enable and applicable global enable all set.
module etpirq_top
    import etpirq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [2:0]  i_ext_irq,
    input  wire logic [3:0]  i_pin_change,
    input  wire logic [3:0]  i_pin_change_is_input,
    input  wire logic        i_timer_tick,
    input  wire logic        i_sleep,
    input  wire logic        i_irq_ack,
    input  wire logic [20:0] i_return_pc,
    input  wire logic [7:0]  i_working_register,
    input  wire logic [7:0]  i_status_reg,
    input  wire logic [7:0]  i_bank_select_register,
    output logic      [7:0]  o_rdata,
    output logic             o_irq_high,
    output logic             o_irq_low,
    output logic             o_wake,
    output logic             o_wake_vector,
    output logic             o_push,
    output logic      [20:0] o_push_pc,
    output logic      [7:0]  o_shadow_working,
    output logic      [7:0]  o_shadow_status,
    output logic      [7:0]  o_shadow_bank,
    output logic             o_event_irq
);

    typedef struct packed {
        logic [7:0]  rst_status;
        logic [7:0]  ctrl_main;
        logic [7:0]  ctrl_second;
        logic [7:0]  ctrl_third;
        logic [15:0] timer;
        logic        timer_16bit;
        logic [2:0]  ext_prev;
        logic [3:0]  pb_snap;
        logic [2:0]  sleep_en;
        logic        sleep_prev;
        logic [EVT_W-1:0] evt_status;
        logic [EVT_W-1:0] evt_enable;
        logic [7:0]  rdata;
        logic        wake;
        logic        wake_vec;
        logic        push;
        logic [20:0] push_pc;
        logic [7:0]  sh_w;
        logic [7:0]  sh_s;
        logic [7:0]  sh_b;
    } etpirq_state_t;

    etpirq_state_t st_r;
    etpirq_state_t st_nxt;

    logic [2:0] ext_edge;
    logic [2:0] ext_flag;
    logic [2:0] ext_en;
    logic [2:0] edge_sel;
    logic       timer_wrap;
    logic [3:0] pb_mismatch;
    logic       prio_on;
    logic       pend_x0, pend_x1, pend_x2, pend_t0, pend_pc;
    logic       hi_req, lo_req, any_pend;
    logic [EVT_W-1:0] evt_set;

    // Per-input edge detection against the previous sample
    assign edge_sel = {st_r.ctrl_second[SEC_EDGE2], st_r.ctrl_second[SEC_EDGE1],
                       st_r.ctrl_second[SEC_EDGE0]};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            assign ext_edge[g] = edge_sel[g] ? (i_ext_irq[g] & ~st_r.ext_prev[g])   // R2
                                             : (~i_ext_irq[g] & st_r.ext_prev[g]);  // R2
        end
    endgenerate

    assign ext_flag = {st_r.ctrl_third[THR_X2IF], st_r.ctrl_third[THR_X1IF],
                       st_r.ctrl_main[MAIN_X0IF]};
    assign ext_en   = {st_r.ctrl_third[THR_X2IE], st_r.ctrl_third[THR_X1IE],
                       st_r.ctrl_main[MAIN_X0IE]};

    // Wrap detection follows the active width
    assign timer_wrap = i_timer_tick & (st_r.timer_16bit ? (st_r.timer == TIMER_MAX16)  // R10
                                                         : (st_r.timer[7:0] == TIMER_MAX8)); // R9
    // Only pins set as inputs take part in the comparison
    assign pb_mismatch = (i_pin_change ^ st_r.pb_snap) & i_pin_change_is_input;

    assign prio_on = st_r.rst_status[RST_PRIO_BIT];  // R1
    // Pending terms: flag and enable both set
    assign pend_x0 = ext_flag[0] & ext_en[0];                                    // R3
    assign pend_x1 = ext_flag[1] & ext_en[1];                                    // R3
    assign pend_x2 = ext_flag[2] & ext_en[2];                                    // R3
    assign pend_t0 = st_r.ctrl_main[MAIN_T0IF] & st_r.ctrl_main[MAIN_TIMER_ZERO_IRQ_ENABLE];      // R11
    assign pend_pc = st_r.ctrl_main[MAIN_PCIF] & st_r.ctrl_main[MAIN_PCIE];      // R13
    assign any_pend = pend_x0 | pend_x1 | pend_x2 | pend_t0 | pend_pc;

    // Priority split; low level exists only while priorities are on
    always_comb begin
        if (prio_on) begin  // R18
            hi_req = pend_x0                                          // R8
                   | (pend_x1 & st_r.ctrl_third[THR_X1IP])            // R7
                   | (pend_x2 & st_r.ctrl_third[THR_X2IP])            // R7
                   | (pend_t0 & st_r.ctrl_second[SEC_T0IP])           // R11
                   | (pend_pc & st_r.ctrl_second[SEC_PCIP]);          // R13
            lo_req = (pend_x1 & ~st_r.ctrl_third[THR_X1IP])
                   | (pend_x2 & ~st_r.ctrl_third[THR_X2IP])
                   | (pend_t0 & ~st_r.ctrl_second[SEC_T0IP])
                   | (pend_pc & ~st_r.ctrl_second[SEC_PCIP]);
            hi_req = hi_req & st_r.ctrl_main[MAIN_GIE];               // R19
            lo_req = lo_req & st_r.ctrl_main[MAIN_GIE] & st_r.ctrl_main[MAIN_PERIPHERAL_IRQ_ENABLE];
        end else begin
            // Main-control sources are core sources; peripheral enable gates none here  // R17
            hi_req = any_pend & st_r.ctrl_main[MAIN_GIE];             // R19
            lo_req = 1'b0;
        end
    end

    // Status bits follow source events only, so a clear sticks while a flag stays pending, unless a pin-change mismatch persists
    assign evt_set = {|pb_mismatch, timer_wrap, ext_edge};

    // Next-state logic: bus writes first, hardware sets override them
    always_comb begin
        st_nxt = st_r;
        st_nxt.push = 1'b0;
        st_nxt.wake = 1'b0;
        st_nxt.wake_vec = 1'b0;
        st_nxt.rdata = 8'h00;
        st_nxt.ext_prev = i_ext_irq;
        st_nxt.sleep_prev = i_sleep;
        if (i_sleep && !st_r.sleep_prev) begin
            st_nxt.sleep_en = ext_en;  // Enables captured at sleep entry  // R5
        end
        if (i_timer_tick) begin
            st_nxt.timer = st_r.timer_16bit ? st_r.timer + 16'h0001
                                            : {st_r.timer[15:8], st_r.timer[7:0] + 8'h01};
        end
        if (i_wr) begin
            if (i_addr == ADDR_RESET_STATUS) begin
                st_nxt.rst_status = (st_r.rst_status & ~RST_WR_MASK) | (i_wdata & RST_WR_MASK); // R16
            end else if (i_addr == ADDR_CTRL_MAIN) begin
                st_nxt.ctrl_main = i_wdata;  // Flags cleared only by software  // R4
            end else if (i_addr == ADDR_CTRL_SECOND) begin
                st_nxt.ctrl_second = i_wdata & SEC_WR_MASK;
            end else if (i_addr == ADDR_CTRL_THIRD) begin
                st_nxt.ctrl_third = i_wdata & THR_WR_MASK;
            end else if (i_addr == ADDR_TIMER_LOW) begin
                st_nxt.timer[7:0] = i_wdata;
            end else if (i_addr == ADDR_TIMER_HIGH) begin
                st_nxt.timer[15:8] = i_wdata;
            end else if (i_addr == ADDR_TIMER_CFG) begin
                st_nxt.timer_16bit = i_wdata[0];
            end else if (i_addr == ADDR_EVT_ENABLE) begin
                st_nxt.evt_enable = i_wdata[EVT_W-1:0];
            end else if (i_addr == ADDR_EVT_CLEAR) begin
                st_nxt.evt_status = st_r.evt_status & ~i_wdata[EVT_W-1:0];
            end else if (i_addr == ADDR_PORTB_SNAP) begin
                st_nxt.pb_snap = i_pin_change;  // Write also ends the mismatch
            end
        end
        if (i_rd) begin
            if (i_addr == ADDR_RESET_STATUS) begin
                st_nxt.rdata = st_r.rst_status & 8'h9F;  // R16
            end else if (i_addr == ADDR_CTRL_MAIN) begin
                st_nxt.rdata = st_r.ctrl_main;
            end else if (i_addr == ADDR_CTRL_SECOND) begin
                st_nxt.rdata = st_r.ctrl_second;
            end else if (i_addr == ADDR_CTRL_THIRD) begin
                st_nxt.rdata = st_r.ctrl_third;
            end else if (i_addr == ADDR_TIMER_LOW) begin
                st_nxt.rdata = st_r.timer[7:0];
            end else if (i_addr == ADDR_TIMER_HIGH) begin
                st_nxt.rdata = st_r.timer[15:8];
            end else if (i_addr == ADDR_TIMER_CFG) begin
                st_nxt.rdata = {7'h00, st_r.timer_16bit};
            end else if (i_addr == ADDR_EVT_STATUS) begin
                st_nxt.rdata = {3'h0, st_r.evt_status};
            end else if (i_addr == ADDR_EVT_ENABLE) begin
                st_nxt.rdata = {3'h0, st_r.evt_enable};
            end else if (i_addr == ADDR_PORTB_SNAP) begin
                st_nxt.rdata = {4'h0, i_pin_change};
                st_nxt.pb_snap = i_pin_change;  // Read latches the compare value
            end
        end
        // Hardware sets win over a same-cycle software clear
        if (ext_edge[0]) st_nxt.ctrl_main[MAIN_X0IF] = 1'b1;    // R3
        if (ext_edge[1]) st_nxt.ctrl_third[THR_X1IF] = 1'b1;    // R3
        if (ext_edge[2]) st_nxt.ctrl_third[THR_X2IF] = 1'b1;    // R3
        if (timer_wrap)  st_nxt.ctrl_main[MAIN_T0IF] = 1'b1;    // R9 R10
        if (|pb_mismatch) st_nxt.ctrl_main[MAIN_PCIF] = 1'b1;   // R12
        st_nxt.evt_status = st_nxt.evt_status | evt_set;
        // Wake on an enabled external flag armed before sleep
        if (st_r.sleep_prev && i_sleep && |(ext_flag & st_r.sleep_en)) begin  // R5
            st_nxt.wake = 1'b1;
            st_nxt.wake_vec = st_r.ctrl_main[MAIN_GIE];  // R6
        end
        // Interrupt entry: save return address and fast context
        if (i_irq_ack) begin
            st_nxt.push = 1'b1;                        // R14
            st_nxt.push_pc = i_return_pc;              // R14
            st_nxt.sh_w = i_working_register;          // R15
            st_nxt.sh_s = i_status_reg;                // R15
            st_nxt.sh_b = i_bank_select_register;      // R15
        end
    end

    // State register with clock enable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.rst_status  <= RST_STATUS_RESET;
            st_r.ctrl_main   <= MAIN_RESET;
            st_r.ctrl_second <= SEC_RESET;
            st_r.ctrl_third  <= THR_RESET;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata          = st_r.rdata;
    assign o_irq_high       = hi_req;
    assign o_irq_low        = lo_req;
    assign o_wake           = st_r.wake;
    assign o_wake_vector    = st_r.wake_vec;
    assign o_push           = st_r.push;
    assign o_push_pc        = st_r.push_pc;
    assign o_shadow_working = st_r.sh_w;
    assign o_shadow_status  = st_r.sh_s;
    assign o_shadow_bank    = st_r.sh_b;
    assign o_event_irq      = |(st_r.evt_status & st_r.evt_enable);

    // Checks
    property p_rst_unimpl;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_rd && i_addr == ADDR_RESET_STATUS) |=> (o_rdata[6:5] == 2'b00);
    endproperty
    a_rst_unimpl: assert property (p_rst_unimpl) else $error("reserved bits nonzero"); // R16

    property p_rise;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && st_r.ctrl_second[SEC_EDGE0] && !st_r.ext_prev[0] && i_ext_irq[0])
            |=> st_r.ctrl_main[MAIN_X0IF];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge lost"); // R2

    property p_flag_sticky;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_r.ctrl_third[THR_X1IF] && !(i_wr && i_addr == ADDR_CTRL_THIRD))
            |=> st_r.ctrl_third[THR_X1IF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // R4

    property p_timer8;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_timer_tick && !st_r.timer_16bit && st_r.timer[7:0] == TIMER_MAX8
         && !(i_wr && i_addr[3:1] == 3'h2))
            |=> (st_r.ctrl_main[MAIN_T0IF] && st_r.timer[7:0] == BYTE_ZERO);
    endproperty
    a_timer8: assert property (p_timer8) else $error("8-bit wrap missed"); // R9

    property p_x0_high;
        @(posedge i_clk) disable iff (i_sys_rst)
        (pend_x0 && st_r.ctrl_main[MAIN_GIE]) |-> (o_irq_high && !(o_irq_low && !prio_on));
    endproperty
    a_x0_high: assert property (p_x0_high) else $error("ext0 not high"); // R8

    property p_single_level;
        @(posedge i_clk) disable iff (i_sys_rst)
        !prio_on |-> !o_irq_low;
    endproperty
    a_single_level: assert property (p_single_level) else $error("low level in legacy"); // R1

    property p_need_gie;
        @(posedge i_clk) disable iff (i_sys_rst)
        !st_r.ctrl_main[MAIN_GIE] |-> !(o_irq_high || o_irq_low);
    endproperty
    a_need_gie: assert property (p_need_gie) else $error("request without global"); // R19

    property p_push;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_irq_ack) |=> (o_push && o_push_pc == $past(i_return_pc)
                                && o_shadow_working == $past(i_working_register));
    endproperty
    a_push: assert property (p_push) else $error("context not saved"); // R14

    c_wake: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_wake && o_wake_vector);
    c_low:  cover property (@(posedge i_clk) disable iff (i_sys_rst) o_irq_low);
    c_pc:   cover property (@(posedge i_clk) disable iff (i_sys_rst) pend_pc && o_irq_high);

endmodule : etpirq_top

// >>> tb/etpirq_core_model.sv
`timescale 1ns/1ps
// Core stand-in: takes each raised request once, after a chosen delay
module etpirq_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_irq,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic      [20:0] o_pc,
    output logic      [7:0]  o_working_register,
    output logic      [7:0]  o_stat,
    output logic      [7:0]  o_bank
);
    logic [3:0] cnt_r = 4'h0;
    logic       busy_r = 1'b0;
    initial {o_ack, o_pc, o_working_register, o_stat, o_bank} = '0;
    // Context moves every cycle, so a copy taken at the wrong edge shows up
    always @(posedge i_clk) begin
        o_ack  <= 1'b0;
        o_pc   <= o_pc + 21'h00007;
        o_working_register <= o_working_register + 8'h13;
        o_stat <= ~o_stat;
        o_bank <= o_bank + 8'h01;
        if (!i_irq) begin
            busy_r <= 1'b0;
            cnt_r  <= 4'h0;
        end else if (!busy_r) begin
            cnt_r <= cnt_r + 4'h1;
            // One take per request; a level that stays up is not taken twice
            if (cnt_r == i_delay) begin
                o_ack  <= 1'b1;
                busy_r <= 1'b1;
            end
        end
    end
endmodule : etpirq_core_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb
    import etpirq_pkg::*;
;
    logic        i_clk, i_sys_rst, i_ce, i_wr, i_rd, i_timer_tick, i_sleep, i_irq_ack;
    logic [3:0]  i_addr, i_pin_change, i_pin_change_is_input, dly, d;
    logic [7:0]  i_wdata, o_rdata, i_working_register, i_status_reg, i_bank_select_register, v;
    logic [2:0]  i_ext_irq;
    logic [20:0] i_return_pc, o_push_pc;
    logic [7:0]  o_shadow_working, o_shadow_status, o_shadow_bank;
    logic        o_irq_high, o_irq_low, o_wake, o_wake_vector, o_push, o_event_irq;
    logic [7:0]  m [16];
    logic [44:0] ctx_q [$];
    logic [44:0] ctx;
    logic        ack_q = 1'b0;
    int          num_errors = 0, checks = 0, seed;

    etpirq_top dut (.i_clk, .i_sys_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_ext_irq,
        .i_pin_change, .i_pin_change_is_input, .i_timer_tick, .i_sleep, .i_irq_ack,
        .i_return_pc, .i_working_register, .i_status_reg, .i_bank_select_register,
        .o_rdata, .o_irq_high, .o_irq_low, .o_wake, .o_wake_vector, .o_push, .o_push_pc,
        .o_shadow_working, .o_shadow_status, .o_shadow_bank, .o_event_irq);
    etpirq_core_model core (.i_clk, .i_irq(o_irq_high | o_irq_low), .i_delay(dly),
        .o_ack(i_irq_ack), .o_pc(i_return_pc), .o_working_register(i_working_register),
        .o_stat(i_status_reg), .o_bank(i_bank_select_register));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Register write, mirrored in the bench image with the documented masks
    task automatic wr(input logic [3:0] a, input logic [7:0] dd);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= dd;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        case (a)
            ADDR_RESET_STATUS: m[a] = (m[a] & ~RST_WR_MASK) | (dd & RST_WR_MASK);
            ADDR_CTRL_SECOND:  m[a] = (m[a] & ~SEC_WR_MASK) | (dd & SEC_WR_MASK);
            ADDR_CTRL_THIRD:   m[a] = (m[a] & ~THR_WR_MASK) | (dd & THR_WR_MASK);
            ADDR_EVT_CLEAR:    m[ADDR_EVT_STATUS] = m[ADDR_EVT_STATUS] & ~dd;
            ADDR_CTRL_MAIN, ADDR_EVT_ENABLE: m[a] = dd;
            default: ;
        endcase
    endtask : wr
    task automatic ckr(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK("register", m[a], o_rdata)
    endtask : ckr
    // Pins are sampled directly against the previous sample; four cycles are allowed to land
    task automatic pin(input int i, input logic lv);
        @(posedge i_clk);
        i_ext_irq[i] <= lv;
        repeat (4) @(posedge i_clk);
    endtask : pin
    task automatic tick;
        @(posedge i_clk);
        i_timer_tick <= 1'b1;
        @(posedge i_clk);
        i_timer_tick <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : tick
    task automatic irqchk(input logic h, input logic l);
        @(negedge i_clk);
        `CHK("irq_high", h, o_irq_high)
        `CHK("irq_low", l, o_irq_low)
    endtask : irqchk
    task automatic waitwake(input logic ex, input logic vec);
        logic seen, vs;
        seen = 1'b0;
        vs   = 1'b0;
        repeat (6) begin
            @(negedge i_clk);
            if (o_wake === 1'b1) begin
                seen = 1'b1;
                vs   = o_wake_vector;
            end
        end
        `CHK("wake", ex, seen)
        if (ex) `CHK("wake_vector", vec, vs)
    endtask : waitwake
    function automatic logic [3:0] fr(input int i);
        return (i == 0) ? ADDR_CTRL_MAIN : ADDR_CTRL_THIRD;
    endfunction : fr
    function automatic int fb(input int i);
        return (i == 0) ? MAIN_X0IF : ((i == 1) ? THR_X1IF : THR_X2IF);
    endfunction : fb
    // A source event sets its own flag and its event status bit
    function automatic void set(input logic [3:0] a, input int b, input int e);
        m[a][b] = 1'b1;
        m[ADDR_EVT_STATUS][e] = 1'b1;
    endfunction : set
    task automatic clr(input logic [3:0] a, input int b, input int e);
        wr(a, m[a] & ~(8'h01 << b));
        wr(ADDR_EVT_CLEAR, 8'h01 << e);
    endtask : clr
    task automatic complete_run;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // Every take must come back as one push carrying that edge's context
    always @(posedge i_clk) begin
        ack_q <= i_irq_ack;
        if (i_irq_ack === 1'b1)
            ctx_q.push_back({i_return_pc, i_working_register, i_status_reg, i_bank_select_register});
    end
    always @(negedge i_clk) begin
        if (i_sys_rst === 1'b0) begin
            `CHK("push", ack_q, o_push)
            if (ack_q === 1'b1 && ctx_q.size() > 0) begin
                ctx = ctx_q.pop_front();
                `CHK("context", ctx, {o_push_pc, o_shadow_working, o_shadow_status, o_shadow_bank})
            end
        end
    end
    // Hang guard sized well above the whole sequence
    initial begin
        #(8 * 30000);
        num_errors++;
        complete_run();
    end
    initial begin
        {i_sys_rst, i_ce, i_wr, i_rd, i_timer_tick, i_sleep} = 6'h30;
        {i_addr, i_wdata, i_ext_irq, i_pin_change, dly} = '0;
        i_pin_change_is_input = 4'hF;
        seed = 32'hD5A9;
        m = '{default: 8'h00};
        m[ADDR_RESET_STATUS] = RST_STATUS_RESET;
        m[ADDR_CTRL_MAIN] = MAIN_RESET;
        m[ADDR_CTRL_SECOND] = SEC_RESET;
        m[ADDR_CTRL_THIRD] = THR_RESET;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 4; a++) ckr(a[3:0]);
        wr(ADDR_RESET_STATUS, 8'hFF);
        ckr(ADDR_RESET_STATUS);
        wr(4'hB, 8'hFF);
        ckr(4'hB);
        // Both polarities per pin; the wrong edge must leave the flag alone
        for (int i = 0; i < 3; i++) begin
            pin(i, 1); set(fr(i), fb(i), i);
            ckr(fr(i));
            ckr(ADDR_EVT_STATUS);
            clr(fr(i), fb(i), i);
            pin(i, 0);
            ckr(fr(i));
            wr(ADDR_CTRL_SECOND, SEC_RESET & ~(8'h01 << (SEC_EDGE0 - i)));
            pin(i, 1);
            ckr(fr(i));
            pin(i, 0); set(fr(i), fb(i), i);
            ckr(fr(i));
            clr(fr(i), fb(i), i);
            wr(ADDR_CTRL_SECOND, SEC_RESET);
        end
        wr(ADDR_RESET_STATUS, 8'h80);
        wr(ADDR_CTRL_MAIN, 8'h80);
        pin(0, 1); set(fr(0), fb(0), 0);
        irqchk(1'b0, 1'b0);
        wr(ADDR_CTRL_MAIN, m[ADDR_CTRL_MAIN] | 8'h10);
        wr(ADDR_EVT_ENABLE, 8'h01);
        irqchk(1'b1, 1'b0);
        `CHK("event_irq", 1'b1, o_event_irq)
        clr(fr(0), fb(0), 0); pin(0, 0);
        irqchk(1'b0, 1'b0);
        `CHK("event_irq", 1'b0, o_event_irq)
        // Ext 1 and 2 under single level, priority levels, and enable gating
        for (int j = 1; j < 3; j++) begin
            wr(ADDR_RESET_STATUS, 8'h00);
            wr(ADDR_CTRL_MAIN, 8'h80);
            wr(ADDR_CTRL_THIRD, 8'h01 << (THR_X1IE + j - 1));
            pin(j, 1); set(fr(j), fb(j), j);
            irqchk(1'b1, 1'b0);
            wr(ADDR_RESET_STATUS, 8'h80);
            irqchk(1'b0, 1'b0);
            wr(ADDR_CTRL_MAIN, 8'hC0);
            irqchk(1'b0, 1'b1);
            wr(ADDR_CTRL_THIRD, m[ADDR_CTRL_THIRD] | (8'h01 << (THR_X1IP + j - 1)));
            irqchk(1'b1, 1'b0);
            wr(ADDR_CTRL_MAIN, 8'h00);
            irqchk(1'b0, 1'b0);
            clr(fr(j), fb(j), j);
            pin(j, 0);
        end
        // A low byte wrap alone counts only in 8-bit mode
        wr(ADDR_CTRL_MAIN, 8'hE0);
        for (int md = 0; md < 2; md++) begin
            wr(ADDR_CTRL_SECOND, SEC_RESET & ~(8'h01 << SEC_T0IP));
            wr(ADDR_TIMER_CFG, md[7:0]);
            wr(ADDR_TIMER_HIGH, 8'h00);
            wr(ADDR_TIMER_LOW, 8'hFF);
            tick();
            if (md == 0) set(ADDR_CTRL_MAIN, MAIN_T0IF, EVT_T0);
            ckr(ADDR_CTRL_MAIN);
            clr(ADDR_CTRL_MAIN, MAIN_T0IF, EVT_T0);
            wr(ADDR_TIMER_HIGH, 8'hFF);
            wr(ADDR_TIMER_LOW, 8'hFE);
            tick();
            ckr(ADDR_CTRL_MAIN);
            tick(); set(ADDR_CTRL_MAIN, MAIN_T0IF, EVT_T0);
            ckr(ADDR_CTRL_MAIN);
            irqchk(1'b0, 1'b1);
            wr(ADDR_CTRL_SECOND, SEC_RESET);
            irqchk(1'b1, 1'b0);
            clr(ADDR_CTRL_MAIN, MAIN_T0IF, EVT_T0);
        end
        // Random pin changes; pins set as outputs are left out of the compare
        wr(ADDR_RESET_STATUS, 8'h00);
        wr(ADDR_CTRL_MAIN, 8'h88);
        for (int k = 0; k < 10; k++) begin
            @(posedge i_clk);
            i_pin_change_is_input <= 4'($random(seed));
            ckr(ADDR_PORTB_SNAP - 4'h1);
            wr(ADDR_PORTB_SNAP, 8'h00);
            clr(ADDR_CTRL_MAIN, MAIN_PCIF, EVT_PC);
            d = 4'($random(seed));
            @(posedge i_clk);
            i_pin_change <= i_pin_change ^ d;
            repeat (4) @(posedge i_clk);
            if ((d & i_pin_change_is_input) != 4'h0) set(ADDR_CTRL_MAIN, MAIN_PCIF, EVT_PC);
            ckr(ADDR_CTRL_MAIN);
            irqchk(m[ADDR_CTRL_MAIN][MAIN_PCIF], 1'b0);
        end
        // Sleep with a slow core; enables taken after sleep must not wake
        wr(ADDR_CTRL_MAIN, 8'h00);
        dly <= 4'h5;
        for (int g = 0; g < 2; g++) begin
            wr(ADDR_CTRL_MAIN, (g == 1) ? 8'h90 : 8'h10);
            wr(ADDR_CTRL_THIRD, 8'h00);
            @(posedge i_clk);
            i_sleep <= 1'b1;
            wr(ADDR_CTRL_THIRD, 8'h08);
            pin(1, 1); set(fr(1), fb(1), 1);
            waitwake(1'b0, 1'b0);
            pin(0, 1); set(fr(0), fb(0), 0);
            waitwake(1'b1, g[0]);
            @(posedge i_clk);
            i_sleep <= 1'b0;
            clr(fr(0), fb(0), 0);
            clr(fr(1), fb(1), 1);
            pin(0, 0); pin(1, 0);
        end
        complete_run();
    end
endmodule : tb
